// ==== sss_shift_store.v ====
// 8-bit serial-in shift register feeding an 8-bit storage register
// with a 16-word queue that receives a copy of each stored byte while it has room
// assumes all pins synchronous to clk_i; the two strobes are sampled levels
// assumes reset_i only starts the block; the two pin clears do the rest
`timescale 1ns/1ps
`include "sss_map.vh"
module sss_shift_store (
   input wire clk_i,
   input wire reset_i,
   input wire serial_data_in_i,
   input wire shift_clock_i,
   input wire shift_clear_n_i,
   input wire storage_clock_i,
   input wire storage_clear_n_i,
   output wire [`SSS_WIDTH-1:0] parallel_out_o,
   output wire serial_cascade_out_o,
   output wire word_valid_o,
   input wire word_ready_i,
   output wire [`SSS_WIDTH-1:0] word_data_o,
   output wire stall_o
);
   // both registers and their next values
   reg [`SSS_WIDTH-1:0] shift_q;
   wire [`SSS_WIDTH-1:0] shift_d;
   reg [`SSS_WIDTH-1:0] store_q;
   wire [`SSS_WIDTH-1:0] store_d;
   // strobe levels seen at the previous clock
   reg shift_clk_q;
   reg store_clk_q;
   // qualified strobe events and decoded clears
   wire shift_rise;
   wire store_rise;
   wire shift_clr;
   wire store_clr;
   wire store_take;
   // stage inputs and clear images
   wire [`SSS_WIDTH-1:0] shift_src;
   wire [`SSS_WIDTH-1:0] shift_init;
   wire [`SSS_WIDTH-1:0] store_init;
   // fifo handshake
   wire fifo_ready;
   // one loop index serves both per-bit loops
   genvar g;

   // edge detect on sampled levels; a falling edge is no event
   // limitation: a strobe must be seen low for one clock between two rises,
   // otherwise the second rise merges with the first and is lost
   function edge_up;
      input cur;
      input prev;
      begin
         edge_up = cur & ~prev;
      end
   endfunction

   // clear decode shared by both registers; the pins are active low
   function clear_on;
      input clear_n;
      begin
         clear_on = ~clear_n;
      end
   endfunction

   // rising edges only; both strobes use the same detector, so a falling
   // strobe can never move either register
   assign shift_rise = edge_up(shift_clock_i, shift_clk_q);
   assign store_rise = edge_up(storage_clock_i, store_clk_q);

   // each register has its own clear
   assign shift_clr = clear_on(shift_clear_n_i);
   assign store_clr = clear_on(storage_clear_n_i);

   // shift strobe history, reset low to match the idle strobe level,
   // so a strobe already high at release counts as a rise
   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         shift_clk_q <= 1'b0;
      end
      else
      begin
         shift_clk_q <= shift_clock_i;
      end
   end

   // storage strobe history; it runs on through a clear, so a rise seen
   // while cleared is consumed and not replayed once the clear lifts
   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         store_clk_q <= 1'b0;
      end
      else
      begin
         store_clk_q <= storage_clock_i;
      end
   end

   // stage 0 listens to the pin, every later stage to the stage before it
   assign shift_src = {shift_q[`SSS_WIDTH-2:0], serial_data_in_i};
   // clear images come from the map, so a different clear value is one edit
   // and both the pin clear and reset_i land on the same value
   assign shift_init = `SSS_SHIFT_RESET;
   assign store_init = `SSS_STORE_RESET;

   // one next-value mux per shift stage; clear is tested first so it
   // overrides the strobe, and without a rise the stage holds its bit
   generate
      for (g = 0; g < `SSS_WIDTH; g = g + 1)
      begin : g_shift
         reg stage_d;
         always @*
         begin
            stage_d = shift_q[g];
            if (shift_clr)
            begin
               stage_d = shift_init[g];
            end
            else if (shift_rise)
            begin
               stage_d = shift_src[g];
            end
         end
         assign shift_d[g] = stage_d;
      end
   endgenerate

   // one next-value mux per storage bit; every bit reads the shift stage as it
   // stood before this clock, so tied strobes leave storage one pulse behind
   generate
      for (g = 0; g < `SSS_WIDTH; g = g + 1)
      begin : g_store
         reg bit_d;
         always @*
         begin
            bit_d = store_q[g];
            if (store_clr)
            begin
               bit_d = store_init[g];
            end
            else if (store_rise)
            begin
               bit_d = shift_q[g];
            end
         end
         assign store_d[g] = bit_d;
      end
   endgenerate

   // shift register; the pin clear acts through shift_d, reset_i only starts it
   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         shift_q <= `SSS_SHIFT_RESET;
      end
      else
      begin
         shift_q <= shift_d;
      end
   end

   // storage register; kept in its own process so each register answers
   // only to its own strobe and clear
   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         store_q <= `SSS_STORE_RESET;
      end
      else
      begin
         store_q <= store_d;
      end
   end

   // the parallel and cascade outputs come straight from flip-flops, so they never glitch between clocks
   // bit 0 of the storage register is the copy of the first stage
   assign parallel_out_o = store_q;
   // the cascade pin is the last stage, so it falls with the shift clear
   assign serial_cascade_out_o = shift_q[`SSS_LAST_STAGE];

   // each stored byte is also queued; a full queue drops the copy, never the load,
   // because the pins have no way to hold off the controller
   // the copy is the same qualified event that loads the storage register
   assign store_take = store_rise & ~store_clr;
   // full is visible so a consumer can tell that copies are being dropped
   assign stall_o = ~fifo_ready;

   // the queue takes the old shift value, the same byte that storage receives
   // on this clock, so queue order matches the order of storage loads
   sss_fifo #(
      .WIDTH(`SSS_WIDTH),
      .DEPTH(`SSS_FIFO_DEPTH),
      .AW(`SSS_FIFO_AW)
   ) u_fifo (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_valid_i(store_take),
      .in_ready_o(fifo_ready),
      .in_data_i(shift_q),
      .out_valid_o(word_valid_o),
      .out_ready_i(word_ready_i),
      .out_data_o(word_data_o)
   );
endmodule

// ==== sss_map.vh ====
// constants for the serial shift and storage register block
// assumes a single 50 MHz clock domain and synchronous pin inputs
`ifndef SSS_MAP_VH
`define SSS_MAP_VH
`define SSS_WIDTH 8
`define SSS_FIFO_DEPTH 16
`define SSS_FIFO_AW 4
`define SSS_CLK_PERIOD_NS 20
`define SSS_SHIFT_RESET 8'h00
`define SSS_STORE_RESET 8'h00
`define SSS_FIRST_STAGE 0
`define SSS_LAST_STAGE 7
`endif

// ==== sss_fifo.v ====
// small synchronous fifo with valid and ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module sss_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
)(
   input wire clk_i,
   input wire reset_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;

   // honest flags from the occupancy count
   assign in_ready_o = (cnt_q != DEPTH[AW:0]);
   assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // storage array has no reset; only pointers and count need one
   always @(posedge clk_i)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // pointer and count update
   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= rd_q + 1'b1;
         end
         if (push & ~pop)
         begin
            cnt_q <= cnt_q + 1'b1;
         end
         else if (pop & ~push)
         begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// ==== sss_shift_store_monitor.sv ====
// checker for the shift and storage block, sees only its ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module sss_shift_store_monitor (
   input wire clk_i,
   input wire reset_i,
   input wire shift_clock_i,
   input wire shift_clear_n_i,
   input wire storage_clock_i,
   input wire storage_clear_n_i,
   input wire [7:0] parallel_out_o,
   input wire serial_cascade_out_o,
   input wire word_valid_o,
   input wire word_ready_i,
   input wire [7:0] word_data_o,
   input wire stall_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   property p_a; !shift_clear_n_i |=> !serial_cascade_out_o; endproperty
   a_a: assert property (p_a) else $error("clear");
   property p_b; !storage_clear_n_i |=> parallel_out_o == 8'h00; endproperty
   a_b: assert property (p_b) else $error("clear");
   property p_c; !storage_clock_i && storage_clear_n_i |=> $stable(parallel_out_o); endproperty
   a_c: assert property (p_c) else $error("hold");
   property p_d; !shift_clock_i && shift_clear_n_i |=> $stable(serial_cascade_out_o); endproperty
   a_d: assert property (p_d) else $error("hold");
   property p_e; $rose(storage_clock_i) && storage_clear_n_i
      |=> parallel_out_o[7] == $past(serial_cascade_out_o); endproperty
   a_e: assert property (p_e) else $error("copy");
   property p_f; $rose(storage_clock_i) && storage_clear_n_i && !word_valid_o
      |=> word_valid_o && word_data_o == parallel_out_o; endproperty
   a_f: assert property (p_f) else $error("push");
   property p_g; stall_o |-> word_valid_o; endproperty
   a_g: assert property (p_g) else $error("stall");
   property p_h; word_valid_o && !word_ready_i |=> word_valid_o; endproperty
   a_h: assert property (p_h) else $error("valid");
endmodule

// ==== sss_ctrl_model.sv ====
// controller model: shifts a byte msb first, then pulses the storage strobe; with tie_i high the storage strobe pulses with each shift strobe
// assumes go_i is a one-cycle request given only while idle
`timescale 1ns/1ps
module sss_ctrl_model (
   input wire clk_i,
   input wire go_i,
   input wire tie_i,
   input wire [7:0] byte_i,
   output wire ser_o,
   output wire sclk_o,
   output wire stclk_o,
   output wire busy_o
);
   reg [4:0] cnt_q = 5'h00;
   reg [7:0] byte_q = 8'h00;
   // two cycles per bit keep the strobe low between rises
   always @(posedge clk_i)
   begin
      cnt_q <= go_i ? 5'h12 : cnt_q - {4'h0, busy_o};
      byte_q <= go_i ? byte_i : byte_q;
   end
   assign busy_o = cnt_q != 5'h00;
   assign sclk_o = cnt_q > 5'h02 && !cnt_q[0];
   assign ser_o = cnt_q > 5'h02 ? byte_q[(cnt_q - 5'h03) >> 1] : cnt_q[0];
   assign stclk_o = tie_i ? sclk_o : cnt_q == 5'h02;
endmodule

// ==== sss_shift_store_tb.sv ====
// testbench for the shift and storage block with a controller model
// assumes the design samples every pin on clk_i
`timescale 1ns/1ps
module sss_shift_store_tb;
   logic clk_i = 0, reset_i = 1, go = 0, tie = 0, shift_clear_n_i = 1, storage_clear_n_i = 1;
   logic word_ready_i = 0, serial_data_in_i, shift_clock_i, storage_clock_i, busy;
   logic word_valid_o, serial_cascade_out_o, stall_o;
   logic [7:0] byte_v = 0, parallel_out_o, word_data_o, i;
   int err_total = 0, tests_run = 0;
   sss_shift_store dut (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .serial_data_in_i(serial_data_in_i),
      .shift_clock_i(shift_clock_i),
      .shift_clear_n_i(shift_clear_n_i),
      .storage_clock_i(storage_clock_i),
      .storage_clear_n_i(storage_clear_n_i),
      .parallel_out_o(parallel_out_o),
      .serial_cascade_out_o(serial_cascade_out_o),
      .word_valid_o(word_valid_o),
      .word_ready_i(word_ready_i),
      .word_data_o(word_data_o),
      .stall_o(stall_o)
   );
   sss_ctrl_model ctl (.clk_i(clk_i), .go_i(go), .tie_i(tie), .byte_i(byte_v),
      .ser_o(serial_data_in_i), .sclk_o(shift_clock_i), .stclk_o(storage_clock_i),
      .busy_o(busy));
   always #10 clk_i = ~clk_i;
   task chk(input string n, input logic [7:0] e, g);
      tests_run++;
      if (e !== g)
      begin
         err_total++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task end_of_test;
      if (err_total == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task send(input logic [7:0] b);
      @(posedge clk_i);
      byte_v <= b;
      go <= 1;
      @(posedge clk_i);
      go <= 0;
      repeat (19) @(posedge clk_i);
      #1;
   endtask
   // fill until refused, then drain in order
   task t_fifo;
      for (i = 0; i < 17; i++) send(i);
      chk("stall", 1, stall_o);
      chk("par", 8'h10, parallel_out_o);
      @(posedge clk_i);
      word_ready_i <= 1;
      #1;
      for (i = 0; i < 16; i++)
      begin
         chk("word", i, word_data_o);
         @(posedge clk_i);
         #1;
      end
      chk("valid", 0, word_valid_o);
   endtask
   // plain load, both clears, then tied strobes
   task t_modes;
      send(8'hA5);
      chk("par", 8'hA5, parallel_out_o);
      chk("cascade", 1, serial_cascade_out_o);
      @(posedge clk_i);
      shift_clear_n_i <= 0;
      send(8'hFF);
      chk("par", 0, parallel_out_o);
      chk("cascade", 0, serial_cascade_out_o);
      @(posedge clk_i);
      shift_clear_n_i <= 1;
      storage_clear_n_i <= 0;
      send(8'h81);
      chk("par", 0, parallel_out_o);
      @(posedge clk_i);
      storage_clear_n_i <= 1;
      tie <= 1;
      send(8'h66);
      chk("tie", 8'hB3, parallel_out_o);
   endtask
   initial
   begin
      repeat (8) @(posedge clk_i);
      reset_i <= 0;
      t_fifo;
      t_modes;
      end_of_test;
   end
   initial
   begin
      repeat (2000) @(posedge clk_i);
      err_total++;
      end_of_test;
   end
endmodule
bind sss_shift_store sss_shift_store_monitor mon (
   .clk_i(clk_i),
   .reset_i(reset_i),
   .shift_clock_i(shift_clock_i),
   .shift_clear_n_i(shift_clear_n_i),
   .storage_clock_i(storage_clock_i),
   .storage_clear_n_i(storage_clear_n_i),
   .parallel_out_o(parallel_out_o),
   .serial_cascade_out_o(serial_cascade_out_o),
   .word_valid_o(word_valid_o),
   .word_ready_i(word_ready_i),
   .word_data_o(word_data_o),
   .stall_o(stall_o)
);
